// file: core/sep_pkg.sv
package sep_pkg;
  // Array organisation
  localparam int unsigned ARRAY_BYTES = 131072;
  localparam int unsigned PAGE_BYTES  = 256;
  localparam int unsigned PAGE_COUNT  = 512;
  localparam int unsigned ADDR_W      = 17;
  localparam logic [8:0]  PCNT_MAX    = 9'h100;
  // Timing and write FIFO depth
  localparam int unsigned CORE_HZ     = 10_000_000;
  localparam int unsigned TW_MS       = 4;
  localparam int unsigned TW_CYCLES   = TW_MS * (CORE_HZ / 1000);
  localparam int unsigned FIFO_DEPTH  = 4;
  // Instruction codes
  localparam logic [7:0]  CMD_WRSR    = 8'h01;
  localparam logic [7:0]  CMD_WRITE   = 8'h02;
  localparam logic [7:0]  CMD_READ    = 8'h03;
  localparam logic [7:0]  CMD_WRDI    = 8'h04;
  localparam logic [7:0]  CMD_RDSR    = 8'h05;
  localparam logic [7:0]  CMD_WREN    = 8'h06;
  localparam logic [7:0]  CMD_WRID    = 8'h82;
  localparam logic [7:0]  CMD_RDID    = 8'h83;
  localparam logic [7:0]  CMD_LOCK    = 8'h92;
  localparam logic [7:0]  CMD_RDLS    = 8'h93;
  // Status byte layout and reset values
  localparam int unsigned SR_WIP_BIT  = 0;
  localparam int unsigned SR_WEL_BIT  = 1;
  localparam int unsigned SR_BP_LSB   = 2;
  localparam logic [1:0]  BP_RESET    = 2'h0;
  localparam logic        WEL_RESET   = 1'b0;
  // Protection settings
  localparam logic [1:0]  BP_QUARTER  = 2'h1;
  localparam logic [1:0]  BP_HALF     = 2'h2;
  localparam logic [1:0]  BP_ALL      = 2'h3;

  typedef enum logic [2:0] {L_CMD, L_ADDR, L_DATA, L_READ, L_SKIP} sep_lstate_t;
  typedef enum logic [1:0] {RS_ARRAY, RS_ID, RS_STATUS, RS_LOCK} sep_rsrc_t;
  typedef enum logic [1:0] {T_ARRAY, T_ID, T_STATUS, T_LOCK} sep_tgt_t;
  typedef enum logic [1:0] {E_IDLE, E_FEED, E_WAIT} sep_estate_t;

  typedef struct packed {
    sep_tgt_t          tgt;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } sep_wr_t;
endpackage

// file: core/sep_stream_if.sv
`timescale 1ns/1ps
interface sep_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// file: core/sep_fifo.sv
`timescale 1ns/1ps
module sep_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Stream in and out
  sep_stream_if.rx in_s,
  sep_stream_if.tx out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] wp_d;
  logic [AW-1:0] rp_q;
  logic [AW-1:0] rp_d;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign in_s.ready  = (cnt_q != FULL_CNT);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rp_q];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb
  begin
    wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (en)
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (en && push)
      mem_q[wp_q] <= in_s.data;
  end
endmodule // sep_fifo

// file: core/sep_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Input bit taken on each rising SCK edge, bytes assembled MSB first.
// R2: Read data shifted out on each falling SCK edge, MSB first.
// R3: Output enable low whenever no read data is being sent.
// R4: Master sends instruction, then address bytes, then write data on MOSI.
// R5: Array of 131072 bytes, 512 pages of 256, up to a whole page written in one write cycle.
// R6: Separate 256-byte ID page, writable until locked except while BP selects whole array, then read only.
// R7: Internal programming finishes within 4 ms for byte or page writes.
// R8: Block protection covers upper quarter, upper half or whole array.
// R9: CS_N low selects and starts a frame; high deselects and floats output.
// R10: Master uses SPI mode 0 or 3; only SCK idle level differs.
// R11: HOLD_N low pauses: output floats, SCK and MOSI ignored; deselect aborts.
// R12: Write discarded unless CS_N rises on byte boundary after a data byte.
// R13: Deselection clears bit counter and instruction state.
module sep_top #(
  parameter int unsigned TW_CYCLES_P = sep_pkg::TW_CYCLES
) (
  // Core clock, enable and reset
  input  wire logic CORE_CLK,
  input  wire logic CLK_EN,
  input  wire logic ARST_N,
  // Serial link
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic MOSI,
  input  wire logic HOLD_N,
  output logic      MISO_O,
  output logic      MISO_OE
);
  import sep_pkg::*;

  localparam int unsigned     TMR_W    = $clog2(TW_CYCLES_P + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(TW_CYCLES_P - 1);

  // Storage
  logic [7:0]        mem_q  [ARRAY_BYTES];
  logic [7:0]        idpg_q [PAGE_BYTES];
  logic [7:0]        pbuf_q [PAGE_BYTES];
  // Reset release
  logic              rst_ff1_q;
  logic              rst_n_q;
  logic              frame_rst_n;
  // Link frame state
  sep_lstate_t       st_q, st_d;
  sep_rsrc_t         rsrc_q, rsrc_d;
  logic [2:0]        bit_q, bit_d;
  logic [6:0]        sh_q, sh_d;
  logic [7:0]        cmd_q, cmd_d;
  logic [1:0]        abyte_q, abyte_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ADDR_W-1:0] raddr_q, raddr_d;
  logic [8:0]        dcnt_q, dcnt_d;
  logic [7:0]        rx_byte;
  logic [7:0]        pb_idx;
  logic [7:0]        rd_byte;
  logic [7:0]        status;
  logic [ADDR_W-1:0] addr_nx;
  logic              pb_we;
  // Link state kept over deselection
  sep_tgt_t          ptgt_q, ptgt_d;
  logic [ADDR_W-1:0] paddr_q, paddr_d;
  logic [8:0]        pcnt_q, pcnt_d;
  logic              parm_q, parm_d;
  logic              wel_q, wel_d;
  logic              busy_l1_q, busy_l2_q;
  logic              lock_l1_q, lock_l2_q;
  logic [1:0]        bp_l1_q, bp_l2_q;
  // Falling edge output stage
  logic [7:0]        obuf_q, obuf_d;
  logic              oe_q, oe_d;
  // Core domain
  logic              cs_s1_q, cs_s2_q, cs_s3_q;
  logic              arm_s1_q, arm_s2_q;
  sep_estate_t       est_q, est_d;
  logic [7:0]        idx_q, idx_d;
  logic [7:0]        foff;
  logic [8:0]        n_q, n_d;
  logic [TMR_W-1:0]  tmr_q, tmr_d;
  logic              busy_q, busy_d;
  logic              lock_q, lock_d;
  logic              hold_q, hold_d;
  logic [1:0]        bp_q, bp_d;
  logic              pop;
  logic              arr_we;
  logic              id_we;
  sep_wr_t           wr;

  sep_stream_if #(.W($bits(sep_wr_t))) feed_s ();
  sep_stream_if #(.W($bits(sep_wr_t))) drain_s ();

  function automatic logic blk_prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    case (bp)
      BP_QUARTER: blk_prot = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
      BP_HALF:    blk_prot = a[ADDR_W-1];
      BP_ALL:     blk_prot = 1'b1;
      default:    blk_prot = 1'b0;
    endcase
  endfunction

  function automatic sep_tgt_t cmd_tgt(input logic [7:0] c);
    case (c)
      CMD_WRITE: cmd_tgt = T_ARRAY;
      CMD_WRID:  cmd_tgt = T_ID;
      CMD_WRSR:  cmd_tgt = T_STATUS;
      default:   cmd_tgt = T_LOCK;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_ff1_q <= 1'b0;
      rst_n_q   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      rst_ff1_q <= 1'b1;
      rst_n_q   <= rst_ff1_q;
    end
  end

  assign frame_rst_n = rst_n_q & ~CS_N; // [R9] [R13]

  // Link decode on rising SCK
  always_comb
  begin
    st_d    = st_q;
    rsrc_d  = rsrc_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    cmd_d   = cmd_q;
    abyte_d = abyte_q;
    addr_d  = addr_q;
    raddr_d = raddr_q;
    dcnt_d  = dcnt_q;
    ptgt_d  = ptgt_q;
    paddr_d = paddr_q;
    pcnt_d  = pcnt_q;
    parm_d  = parm_q;
    wel_d   = wel_q;
    pb_we   = 1'b0;
    rx_byte = {sh_q, MOSI}; // [R1]
    addr_nx = {addr_q[ADDR_W-9:0], rx_byte};
    pb_idx  = addr_q[7:0] + dcnt_q[7:0];
    if (!CS_N && HOLD_N) // [R11]
    begin
      bit_d  = bit_q + 3'h1; // [R1]
      sh_d   = rx_byte[6:0];
      parm_d = 1'b0; // [R12]
      if (st_q == L_CMD && bit_q == 3'h0 && parm_q)
        wel_d = 1'b0;
      if (bit_q == 3'h7)
      begin
        case (st_q)
          L_CMD:
          begin
            cmd_d = rx_byte;
            st_d  = L_SKIP;
            if (rx_byte == CMD_RDSR)
            begin
              st_d   = L_READ;
              rsrc_d = RS_STATUS;
            end
            else if (!busy_l2_q)
            begin
              case (rx_byte)
                CMD_WREN: wel_d = 1'b1;
                CMD_WRDI: wel_d = 1'b0;
                CMD_READ, CMD_RDID: st_d = L_ADDR;
                CMD_RDLS:
                begin
                  st_d   = L_READ;
                  rsrc_d = RS_LOCK;
                end
                CMD_WRITE, CMD_WRID, CMD_WRSR, CMD_LOCK:
                begin
                  if (wel_q)
                  begin
                    st_d    = (rx_byte == CMD_WRITE || rx_byte == CMD_WRID) ? L_ADDR : L_DATA;
                    ptgt_d  = cmd_tgt(rx_byte);
                    paddr_d = '0;
                    pcnt_d  = '0;
                  end
                end
                default: st_d = L_SKIP;
              endcase
            end
          end
          L_ADDR:
          begin
            addr_d  = addr_nx;
            abyte_d = abyte_q + 2'h1;
            if (abyte_q == 2'h2)
            begin
              raddr_d = addr_nx;
              st_d    = L_DATA;
              if (cmd_q == CMD_READ)
              begin
                st_d   = L_READ;
                rsrc_d = RS_ARRAY;
              end
              else if (cmd_q == CMD_RDID)
              begin
                st_d   = L_READ;
                rsrc_d = RS_ID;
              end
              else
                paddr_d = addr_nx;
            end
          end
          L_DATA:
          begin
            pb_we  = 1'b1;
            dcnt_d = dcnt_q + 9'h1;
            parm_d = 1'b1; // [R12]
            if (pcnt_q != PCNT_MAX)
              pcnt_d = pcnt_q + 9'h1;
          end
          L_READ: raddr_d = raddr_q + 17'h1;
          default: st_d = st_q;
        endcase
      end
    end
  end

  always_ff @(posedge SCK or negedge frame_rst_n)
  begin
    if (!frame_rst_n) // [R13]
    begin
      st_q    <= L_CMD;
      rsrc_q  <= RS_STATUS;
      bit_q   <= 3'h0;
      sh_q    <= 7'h00;
      cmd_q   <= 8'h00;
      abyte_q <= 2'h0;
      addr_q  <= '0;
      raddr_q <= '0;
      dcnt_q  <= 9'h000;
    end
    else
    begin
      st_q    <= st_d;
      rsrc_q  <= rsrc_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      cmd_q   <= cmd_d;
      abyte_q <= abyte_d;
      addr_q  <= addr_d;
      raddr_q <= raddr_d;
      dcnt_q  <= dcnt_d;
    end
  end

  // Pending write and status copies survive deselection
  always_ff @(posedge SCK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ptgt_q    <= T_ARRAY;
      paddr_q   <= '0;
      pcnt_q    <= 9'h000;
      parm_q    <= 1'b0;
      wel_q     <= WEL_RESET;
      busy_l1_q <= 1'b0;
      busy_l2_q <= 1'b0;
      lock_l1_q <= 1'b0;
      lock_l2_q <= 1'b0;
      bp_l1_q   <= BP_RESET;
      bp_l2_q   <= BP_RESET;
    end
    else
    begin
      ptgt_q    <= ptgt_d;
      paddr_q   <= paddr_d;
      pcnt_q    <= pcnt_d;
      parm_q    <= parm_d;
      wel_q     <= wel_d;
      busy_l1_q <= busy_q;
      busy_l2_q <= busy_l1_q;
      lock_l1_q <= lock_q;
      lock_l2_q <= lock_l1_q;
      bp_l1_q   <= bp_q;
      bp_l2_q   <= bp_l1_q;
    end
  end

  // Page buffer, index wraps inside the page
  always_ff @(posedge SCK)
  begin
    if (pb_we)
      pbuf_q[pb_idx] <= rx_byte;
  end

  // Read source select
  always_comb
  begin
    status             = 8'h00;
    status[SR_WIP_BIT] = busy_l2_q;
    status[SR_WEL_BIT] = wel_q;
    status[SR_BP_LSB +: 2] = bp_l2_q;
    case (rsrc_q)
      RS_ARRAY:  rd_byte = mem_q[raddr_q];
      RS_ID:     rd_byte = idpg_q[raddr_q[7:0]];
      RS_STATUS: rd_byte = status;
      default:   rd_byte = {7'h00, lock_l2_q};
    endcase
  end

  // Output shifter on falling SCK
  always_comb
  begin
    obuf_d = obuf_q;
    oe_d   = oe_q;
    if (HOLD_N) // [R11]
    begin
      obuf_d = {obuf_q[6:0], 1'b0}; // [R2]
      if (st_q == L_READ && bit_q == 3'h0)
      begin
        obuf_d = rd_byte; // [R2]
        oe_d   = 1'b1;
      end
    end
  end

  always_ff @(negedge SCK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      obuf_q <= 8'h00;
      oe_q   <= 1'b0;
    end
    else
    begin
      obuf_q <= obuf_d;
      oe_q   <= oe_d;
    end
  end

  assign MISO_O  = obuf_q[7];
  assign MISO_OE = oe_q & HOLD_N & ~CS_N; // [R3] [R9] [R11]

  // Core side synchronisers
  always_ff @(posedge CORE_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      arm_s1_q <= 1'b0;
      arm_s2_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      cs_s1_q  <= CS_N;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      arm_s1_q <= parm_q;
      arm_s2_q <= arm_s1_q;
    end
  end

  // Write engine: feed page bytes into FIFO, drain into storage
  always_comb
  begin
    est_d   = est_q;
    idx_d   = idx_q;
    n_d     = n_q;
    busy_d  = busy_q;
    bp_d    = bp_q;
    lock_d  = lock_q;
    tmr_d   = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    foff    = paddr_q[7:0] + idx_q;
    feed_s.valid = (est_q == E_FEED);
    feed_s.data  = {ptgt_q, paddr_q[ADDR_W-1:8], foff, pbuf_q[foff]};
    wr      = sep_wr_t'(drain_s.data);
    drain_s.ready = ~hold_q;
    pop     = drain_s.valid & ~hold_q;
    hold_d  = pop;
    arr_we  = pop && wr.tgt == T_ARRAY && !blk_prot(wr.addr, bp_q); // [R5] [R8]
    id_we   = pop && wr.tgt == T_ID && !lock_q && bp_q != BP_ALL; // [R6] [R8]
    if (pop && wr.tgt == T_STATUS)
      bp_d = wr.data[SR_BP_LSB +: 2];
    if (pop && wr.tgt == T_LOCK)
      lock_d = 1'b1; // [R6]
    case (est_q)
      E_IDLE:
      begin
        if (cs_s2_q && !cs_s3_q && arm_s2_q) // [R12]
        begin
          est_d  = E_FEED;
          idx_d  = 8'h00;
          n_d    = pcnt_q;
          tmr_d  = TMR_LOAD; // [R7]
          busy_d = 1'b1;
        end
      end
      E_FEED:
      begin
        if (feed_s.ready)
        begin
          idx_d = idx_q + 8'h01;
          if ({1'b0, idx_q} == n_q - 9'h001)
            est_d = E_WAIT;
        end
      end
      E_WAIT:
      begin
        if (tmr_q == '0 && !drain_s.valid) // [R7]
        begin
          est_d  = E_IDLE;
          busy_d = 1'b0;
        end
      end
      default: est_d = E_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      est_q  <= E_IDLE;
      idx_q  <= 8'h00;
      n_q    <= 9'h000;
      tmr_q  <= '0;
      busy_q <= 1'b0;
      bp_q   <= BP_RESET;
      lock_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      est_q  <= est_d;
      idx_q  <= idx_d;
      n_q    <= n_d;
      tmr_q  <= tmr_d;
      busy_q <= busy_d;
      bp_q   <= bp_d;
      lock_q <= lock_d;
      hold_q <= hold_d;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (CLK_EN && arr_we)
      mem_q[wr.addr] <= wr.data; // [R5]
    if (CLK_EN && id_we)
      idpg_q[wr.addr[7:0]] <= wr.data; // [R6]
  end

  sep_fifo #(
    .W     ($bits(sep_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (CORE_CLK),
    .rst_n (rst_n_q),
    .en    (CLK_EN),
    .in_s  (feed_s),
    .out_s (drain_s)
  );
endmodule // sep_top

// file: test/sep_top_checker.sv
`timescale 1ns/1ps
module sep_top_checker
  import sep_pkg::*;
#(
  parameter int unsigned TW_CYCLES_P = 300
) (
  // Core side
  input wire logic CORE_CLK,
  input wire logic CLK_EN,
  input wire logic ARST_N,
  // Serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic MOSI,
  input wire logic HOLD_N,
  input wire logic MISO_O,
  input wire logic MISO_OE
);
  logic [11:0] rise_cnt;
  logic [7:0]  cmd_q;
  logic        rise_val;
  logic        rise_oe;
  wire         frame_off = CS_N || !ARST_N;
  // Rising edges and command byte of the current frame
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      rise_cnt <= 12'h000;
      cmd_q    <= 8'h00;
    end
    else if (HOLD_N)
    begin
      rise_cnt <= rise_cnt + 12'h001;
      cmd_q    <= (rise_cnt < 12'h008) ? {cmd_q[6:0], MOSI} : cmd_q;
    end
  end
  always_ff @(posedge SCK)
  begin
    rise_val <= MISO_O;
    rise_oe  <= MISO_OE;
  end
  property p_oe_cs; @(posedge CORE_CLK) disable iff (!ARST_N) CS_N |-> !MISO_OE; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
  property p_oe_hold; @(posedge CORE_CLK) disable iff (!ARST_N) !HOLD_N |-> !MISO_OE; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output driven during pause");
  property p_bit_steady; @(negedge SCK) disable iff (frame_off) MISO_OE && rise_oe |-> MISO_O == rise_val; endproperty
  a_bit_steady: assert property (p_bit_steady) else $error("output bit moved while clock high");
  property p_oe_on_byte;
    @(negedge SCK) disable iff (frame_off) $rose(MISO_OE) && $past(HOLD_N) |-> rise_cnt[2:0] == 3'h1;
  endproperty
  a_oe_on_byte: assert property (p_oe_on_byte) else $error("output started off a byte boundary");
  property p_oe_keeps;
    @(posedge SCK) disable iff (frame_off) rise_cnt != 12'h000 && $past(MISO_OE) && $past(HOLD_N) && HOLD_N |-> MISO_OE;
  endproperty
  a_oe_keeps: assert property (p_oe_keeps) else $error("output released inside a read");
  property p_addr_quiet;
    @(posedge SCK) disable iff (frame_off) cmd_q == CMD_READ && rise_cnt inside {[12'h008:12'h01f]} |-> !MISO_OE;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("output driven during address");
  property p_status_out;
    @(posedge SCK) disable iff (frame_off) cmd_q == CMD_RDSR && rise_cnt == 12'h008 && HOLD_N |-> MISO_OE;
  endproperty
  a_status_out: assert property (p_status_out) else $error("status byte not driven");
  property p_read_out;
    @(posedge SCK) disable iff (frame_off) cmd_q == CMD_READ && rise_cnt == 12'h020 && HOLD_N |-> MISO_OE;
  endproperty
  a_read_out: assert property (p_read_out) else $error("read data not driven after address");
  c_read_byte: cover property (@(posedge SCK) cmd_q == CMD_READ && rise_cnt == 12'h028 && MISO_OE);
  c_status: cover property (@(posedge SCK) cmd_q == CMD_RDSR && MISO_OE);
  c_pause: cover property (@(posedge CORE_CLK) !HOLD_N && !CS_N);
endmodule // sep_top_checker
bind sep_top sep_top_checker #(.TW_CYCLES_P(TW_CYCLES_P)) u_chk (
  .CORE_CLK(CORE_CLK), .CLK_EN(CLK_EN), .ARST_N(ARST_N), .SCK(SCK), .CS_N(CS_N),
  .MOSI(MOSI), .HOLD_N(HOLD_N), .MISO_O(MISO_O), .MISO_OE(MISO_OE));

// file: test/sep_spi_master.sv
`timescale 1ns/1ps
module sep_spi_master (
  // Link lines
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  output logic      hold_n,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  localparam realtime HALF = 7.5;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic       mode3 = 1'b0;
  logic       hold_oe = 1'b0;
  // Undriven line reads as z
  wire        miso = miso_oe ? miso_o : 1'bz;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    hold_n = 1'b1;
  end
  task automatic byte_io(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      sck = 1'b0;
      mosi = tx[i];
      #HALF;
      sck = 1'b1;
      rx[i] = miso;
      #HALF;
    end
  endtask
  task automatic pause();
    sck = 1'b0;
    #HALF;
    hold_n = 1'b0;
    #HALF;
    hold_oe = miso_oe;
    // Clock and data wiggle meant to be ignored
    for (int i = 0; i < 8; i++)
    begin
      sck = 1'b1;
      mosi = ~mosi;
      #HALF;
      sck = 1'b0;
      #HALF;
    end
    hold_n = 1'b1;
    #HALF;
  endtask
  task automatic frame(input int nrd, input int tail, input int hold_at);
    logic [7:0] b;
    int         n;
    n = txq.size();
    rxq = {};
    sck = mode3;
    #20;
    cs_n = 1'b0;
    #20;
    for (int k = 0; k < n + nrd; k++)
    begin
      if (k == hold_at)
        pause();
      byte_io(k < n ? txq[k] : 8'(k), 8, b);
      if (k >= n)
        rxq.push_back(b);
    end
    if (tail > 0)
      byte_io(8'ha5, tail, b);
    sck = mode3;
    #HALF;
    cs_n = 1'b1;
    mosi = ~mosi;
    #500;
  endtask
endmodule // sep_spi_master

// file: test/tb_spi_eeprom_serial_port.sv
`timescale 1ns/1ps
module tb_spi_eeprom_serial_port;
  import sep_pkg::*;
  localparam int unsigned TW = 300;
  logic        core_clk;
  logic        clk_en;
  logic        arst_n;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  logic        hold_n;
  logic        miso_o;
  logic        miso_oe;
  int          num_errors;
  int          comparisons;
  logic [31:0] seed;
  logic [1:0]  bp;
  logic [7:0]  mem[logic [16:0]];
  logic [7:0]  idp[logic [7:0]];
  logic [16:0] al[$];
  logic [16:0] probe[3] = '{17'h18000, 17'h10000, 17'h00000};

  sep_top #(.TW_CYCLES_P(TW)) u_dut (.CORE_CLK(core_clk), .CLK_EN(clk_en), .ARST_N(arst_n), .SCK(sck),
    .CS_N(cs_n), .MOSI(mosi), .HOLD_N(hold_n), .MISO_O(miso_o), .MISO_OE(miso_oe));
  sep_spi_master u_mst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic prot(logic [1:0] b, logic [16:0] a);
    return (b == BP_ALL) || (b == BP_HALF && a[16]) || (b == BP_QUARTER && a[16:15] == 2'h3);
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp || $isunknown(got))
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic run(input int nrd, input int tail, input int hold_at);
    @(negedge core_clk);
    u_mst.frame(nrd, tail, hold_at);
  endtask
  task automatic send(input logic [7:0] c, input int nrd);
    u_mst.txq = {c};
    run(nrd, 0, -1);
  endtask
  task automatic wait_ready(input logic busy);
    realtime t0;
    logic    ok_t;
    t0 = $realtime;
    send(CMD_RDSR, 1);
    if (busy)
      chk("busy flag", 8'h01, u_mst.rxq[0] & 8'h01);
    for (int i = 0; i < 100 && u_mst.rxq[0][0] !== 1'b0; i++)
      send(CMD_RDSR, 1);
    chk("ready", 8'h00, u_mst.rxq[0] & 8'h01);
    ok_t = ($realtime - t0) <= (TW + 60) * 100.0 && ($realtime - t0) >= (TW - 5) * 100.0;
    if (busy)
      chk("write time", 8'h01, {7'h0, ok_t});
    if (busy)
      chk("status", {4'h0, bp, 2'h0}, u_mst.rxq[0]);
  endtask
  task automatic wr(input logic [7:0] c, input logic [16:0] a, input int n, input logic upd, input int tail);
    logic [7:0] d;
    send(CMD_WREN, 0);
    u_mst.txq = {c, 8'(a[16]), a[15:8], a[7:0]};
    if (c == CMD_WRSR || c == CMD_LOCK)
      u_mst.txq = {c, a[7:0]};
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      u_mst.txq.push_back(d);
      if (upd && c == CMD_WRITE)
        mem[{a[16:8], a[7:0] + 8'(i)}] = d;
      if (upd && c == CMD_WRID)
        idp[a[7:0] + 8'(i)] = d;
    end
    run(0, tail, -1);
    wait_ready(upd);
  endtask
  task automatic rd(input logic [7:0] c, input logic [16:0] a, input int n, input int hold_at);
    u_mst.txq = {c, 8'(a[16]), a[15:8], a[7:0]};
    run(n, 0, hold_at);
    for (int i = 0; i < n; i++)
      chk("read byte", c == CMD_READ ? mem[a + 17'(i)] : idp[a[7:0] + 8'(i)], u_mst.rxq[i]);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    #4_000_000;
    num_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    give_verdict();
  end
  initial
  begin
    clk_en = 1'b1;
    arst_n = 1'b0;
    seed = 32'hc42f;
    bp = 2'h0;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    // Array ends, page wrap and random places, both clock idle levels
    for (int i = 0; i < 6; i++)
    begin
      u_mst.mode3 = i[0];
      al.push_back(i < 2 ? {17{i[0]}} : 17'(rnd()));
      wr(CMD_WRITE, al[i], 1 + i, 1'b1, 0);
    end
    foreach (al[i])
      rd(CMD_READ, al[i], 1, -1);
    rd(CMD_READ, 17'h1ffff, 2, -1);
    rd(CMD_READ, 17'h1ff00, 1, 2);
    rd(CMD_READ, 17'h1ffff, 2, 5);
    chk("pause output enable", 8'h00, {7'h0, u_mst.hold_oe});
    // Writes that must be dropped
    wr(CMD_WRITE, 17'h0, 1, 1'b0, 3);
    wr(CMD_WRITE, 17'h0, 0, 1'b0, 0);
    rd(CMD_READ, 17'h0, 1, -1);
    // Abandoned frame then fresh status read
    send(CMD_WRDI, 0);
    u_mst.txq = {};
    run(0, 5, -1);
    send(CMD_RDSR, 1);
    chk("status after abort", 8'h00, u_mst.rxq[0]);
    // Write without enable latch is ignored
    u_mst.txq = {CMD_WRITE, 8'h00, 8'h00, 8'h00, ~mem[17'h0]};
    run(0, 0, -1);
    rd(CMD_READ, 17'h0, 1, -1);
    // Identification page, lock
    wr(CMD_WRID, 17'h0fe, 2, 1'b1, 0);
    rd(CMD_RDID, 17'h0fe, 2, -1);
    send(CMD_RDLS, 1);
    chk("lock before", 8'h00, u_mst.rxq[0]);
    wr(CMD_LOCK, 17'h1, 0, 1'b1, 0);
    send(CMD_RDLS, 1);
    chk("lock after", 8'h01, u_mst.rxq[0]);
    wr(CMD_WRID, 17'h0fe, 2, 1'b0, 0);
    rd(CMD_RDID, 17'h0fe, 2, -1);
    // Frozen core stretches the write cycle, busy refuses enable
    send(CMD_WREN, 0);
    u_mst.txq = {CMD_WRITE, 8'h00, 8'h12, 8'h34, 8'h5a};
    run(0, 0, -1);
    @(negedge core_clk);
    clk_en = 1'b0;
    repeat (400) @(negedge core_clk);
    send(CMD_RDSR, 1);
    chk("frozen busy", 8'h01, u_mst.rxq[0] & 8'h01);
    send(CMD_WREN, 0);
    @(negedge core_clk);
    clk_en = 1'b1;
    mem[17'h01234] = 8'h5a;
    wait_ready(1'b1);
    rd(CMD_READ, 17'h01234, 1, -1);
    // Known contents at every probe before protection
    foreach (probe[j])
      wr(CMD_WRITE, probe[j], 1, 1'b1, 0);
    // Each protection setting against probes in every region
    for (int b = 1; b < 4; b++)
    begin
      bp = 2'(b);
      wr(CMD_WRSR, {13'h0, bp, 2'h0}, 0, 1'b1, 0);
      foreach (probe[j])
        wr(CMD_WRITE, probe[j], 1, !prot(bp, probe[j]), 0);
      foreach (probe[j])
        rd(CMD_READ, probe[j], 1, -1);
    end
    give_verdict();
  end
endmodule // tb_spi_eeprom_serial_port
